// ---- common/emc_pkg.sv ----
// constants and state type for the expanded memory map control
package emc_pkg;
	localparam logic [15:0] OFS_MASTER = 16'h0010;
	localparam logic [15:0] OFS_CUR_PTR = 16'h0011;
	localparam logic [15:0] OFS_CUR_DATA = 16'h0012;
	localparam logic [15:0] OFS_DMA_TAG = 16'h0014;
	localparam logic [15:0] OFS_ALT_PTR = 16'h0015;
	localparam logic [15:0] OFS_ALT_DATA = 16'h0016;
	localparam logic [15:0] OFS_PARITY = 16'h0018;
	localparam logic [15:0] OFS_BANK_CTRL = 16'h001c;
	localparam logic [15:0] OFS_PWR_EN = 16'h001e;
	localparam int MAP_WORDS = 36;
	localparam int LOW_SLOTS = 24;
	localparam logic [5:0] LOW_FIRST = 6'h10;
	localparam logic [5:0] LOW_LAST = 6'h27;
	localparam logic [5:0] HIGH_FIRST = 6'h30;
	localparam logic [5:0] HIGH_LAST = 6'h3b;
	localparam int ENT_EN = 7;
	localparam int ALT_SHIFT = 0;
	localparam int CUR_SHIFT = 4;
	localparam int PAR_FLAG = 7;
	localparam int PAR_ODD = 5;
	localparam int PAR_EVEN = 4;
	localparam logic [7:0] PAR_WMASK = 8'hbf;
	localparam logic [7:0] RST_MASTER = 8'h00;
	localparam logic [7:0] RST_DMA_TAG = 8'h00;
	localparam logic [7:0] RST_PARITY = 8'h00;
	localparam int CLK_NS = 10;
	localparam int OUT_CLK_PERIOD_NS = 100;
	localparam int HALF_CYC = OUT_CLK_PERIOD_NS / (2 * CLK_NS);
	localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);

	typedef struct packed {
		logic [1:0] master_en;
		logic [7:0] dma_tag;
		logic [5:0] cur_ptr;
		logic [5:0] alt_ptr;
		logic [MAP_WORDS-1:0][9:0] cur_map;
		logic [MAP_WORDS-1:0][9:0] alt_map;
		logic [7:0] par_en;
		logic [7:0] par_stat;
		logic pwr_fn;
		logic banks_off;
		logic cpu_stopped;
		logic [1:0] interrupt_request_in_sync;
		logic [3:0] div_cnt;
		logic sys_clk;
		logic cpu_clk;
		logic [15:0] rdata;
		logic [3:0] ras;
		logic to_ems;
		logic to_sys;
		logic to_io;
		logic [8:0] phys;
	} emc_state_t;
endpackage

// ---- src/emc_ctrl.sv ----
// expanded memory map control: maps, row strobes, parity status, power
//
// What this block does
// R1: channel n uses tag bit n as alternate select, bit n+4 as current
// R2: dma with both select bits clear is not translated
// R3: dma alternate bit wins; current map only with current bit alone
// R4: cpu cycles: none, current if bit0 set, alternate if bit1 alone
// R5: dma tag register clears to zero at reset
// R6: disabled page goes to system memory, or i/o channel if disabled
// R7: translated access drives one of four bank row strobes from entry
// R8: 8-bit parity status port identifies expanded memory parity errors
// R9: read gives flag bit7, bit6 zero, odd byte bit5, even bit4
// R10: read bits 3..0 mark banks 3..0 bad
// R11: write bits 7,5,4,3..0 enable checking per source
// R12: writing zero to a status bit clears it
// R13: parity status port clears to zero at reset
// R14: after power enable write, bank-control write enables or disables banks
// R15: with power enabled, bank-control read disables banks, stops cpu clock
// R16: interrupt request restarts the stopped cpu clock
// R17: system clock keeps running during cpu clock shutdown
// R18: master enable bit0 current, bit1 alternate, zero at reset
// R19: entry bit7 enables page, other bits give address 22..14
// R20: current and alternate maps are 36 by 10 bit files
// R21: dma tag register is a read/write i/o port
// R22: untranslated access keeps row strobes inactive except refresh
`timescale 1ns/10ps
module emc_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [15:0] io_wdata,
	output logic [15:0] io_rdata,
	input wire logic mem_cycle,
	input wire logic dma_cycle,
	input wire logic [1:0] dma_channel,
	input wire logic [5:0] mem_block,
	input wire logic planar_disabled,
	input wire logic refresh,
	output logic [3:0] bank_row_strobe_n,
	output logic [8:0] phys_addr,
	output logic route_ems,
	output logic route_system,
	output logic route_io_channel,
	input wire logic parity_event,
	input wire logic parity_odd,
	input wire logic parity_even,
	input wire logic [3:0] parity_bank,
	input wire logic interrupt_request_in,
	output logic processor_clock_out,
	output logic system_clock_out,
	output logic register_banks_enabled
);
	import emc_pkg::*;

	emc_state_t q;
	emc_state_t next_q;

	// map 16k block number to a map slot; ok low when block unmappable
	function automatic logic [6:0] slot_of(input logic [5:0] blk);
		logic [5:0] s;
		logic ok;
		s = 6'h00;
		ok = 1'b0;
		if (blk >= LOW_FIRST && blk <= LOW_LAST) begin
			s = blk - LOW_FIRST;
			ok = 1'b1;
		end else if (blk >= HIGH_FIRST && blk <= HIGH_LAST) begin
			s = blk - HIGH_FIRST + 6'(LOW_SLOTS);
			ok = 1'b1;
		end
		return {ok, s};
	endfunction

	logic [6:0] blk_slot;
	logic [6:0] cur_slot;
	logic [6:0] alt_slot;
	logic sel_any;
	logic sel_alt;
	logic [9:0] entry;
	logic mapped;
	logic [7:0] par_src;
	logic [7:0] par_set;
	logic tick;
	logic [3:0] chan_alt;
	logic [3:0] chan_cur;

	// per-channel select pair taken from the tag register
	for (genvar n = 0; n < 4; n++) begin : g_chan
		assign chan_alt[n] = q.dma_tag[n + ALT_SHIFT]; //R1
		assign chan_cur[n] = q.dma_tag[n + CUR_SHIFT]; //R1
	end

	always_comb begin
		blk_slot = slot_of(mem_block);
		cur_slot = slot_of(q.cur_ptr);
		alt_slot = slot_of(q.alt_ptr);
		if (dma_cycle) begin
			sel_any = chan_alt[dma_channel] | chan_cur[dma_channel]; //R1 R2
			sel_alt = chan_alt[dma_channel]; //R3
		end else begin
			sel_any = |q.master_en; //R4 R18
			sel_alt = q.master_en == 2'b10; //R4
		end
		entry = 10'h000;
		if (blk_slot[6]) begin
			entry = sel_alt ? q.alt_map[blk_slot[5:0]] : q.cur_map[blk_slot[5:0]]; //R20
		end
		mapped = mem_cycle & sel_any & blk_slot[6] & entry[ENT_EN] & ~q.banks_off; //R19
		par_src = {1'b1, 1'b0, parity_odd, parity_even, parity_bank};
		par_set = parity_event ? (par_src & q.par_en) : 8'h00; //R11
		tick = q.div_cnt == HALF_LAST;
	end

	always_comb begin
		next_q = q;
		// translation, registered one cycle after the cycle inputs
		next_q.to_ems = mapped;
		next_q.to_sys = mem_cycle & ~mapped & ~planar_disabled; //R6
		next_q.to_io = mem_cycle & ~mapped & planar_disabled; //R6
		next_q.phys = {entry[9:8], entry[6:0]}; //R19
		if (refresh) begin
			next_q.ras = 4'hf;
		end else if (mapped) begin
			next_q.ras = 4'h1 << entry[9:8]; //R7
		end else begin
			next_q.ras = 4'h0; //R22
		end
		// parity status: set wins over a clearing write
		next_q.par_stat = q.par_stat | par_set; //R8 R10
		if (io_wr) begin
			case (io_addr)
				OFS_MASTER: next_q.master_en = io_wdata[1:0]; //R18
				OFS_CUR_PTR: next_q.cur_ptr = io_wdata[5:0];
				OFS_ALT_PTR: next_q.alt_ptr = io_wdata[5:0];
				OFS_DMA_TAG: next_q.dma_tag = io_wdata[7:0]; //R21
				OFS_CUR_DATA: begin
					if (cur_slot[6] && !q.banks_off) begin
						next_q.cur_map[cur_slot[5:0]] = io_wdata[9:0];
					end
				end
				OFS_ALT_DATA: begin
					if (alt_slot[6] && !q.banks_off) begin
						next_q.alt_map[alt_slot[5:0]] = io_wdata[9:0];
					end
				end
				OFS_PARITY: begin
					next_q.par_en = io_wdata[7:0] & PAR_WMASK; //R11
					next_q.par_stat = (q.par_stat & io_wdata[7:0] & PAR_WMASK) | par_set; //R12
				end
				OFS_BANK_CTRL: begin
					if (q.pwr_fn) begin
						next_q.banks_off = ~io_wdata[0]; //R14
					end
				end
				OFS_PWR_EN: next_q.pwr_fn = io_wdata[0]; //R14
				default: next_q.pwr_fn = q.pwr_fn;
			endcase
		end
		if (io_rd) begin
			case (io_addr)
				OFS_MASTER: next_q.rdata = {14'h0000, q.master_en};
				OFS_CUR_PTR: next_q.rdata = {10'h000, q.cur_ptr};
				OFS_ALT_PTR: next_q.rdata = {10'h000, q.alt_ptr};
				OFS_DMA_TAG: next_q.rdata = {8'h00, q.dma_tag}; //R21
				OFS_CUR_DATA: next_q.rdata = cur_slot[6] ? {6'h00, q.cur_map[cur_slot[5:0]]} : 16'h0000;
				OFS_ALT_DATA: next_q.rdata = alt_slot[6] ? {6'h00, q.alt_map[alt_slot[5:0]]} : 16'h0000;
				OFS_PARITY: next_q.rdata = {8'h00, q.par_stat}; //R9 R10
				OFS_BANK_CTRL: begin
					next_q.rdata = {15'h0000, ~q.banks_off};
					if (q.pwr_fn) begin
						next_q.banks_off = 1'b1; //R15
						next_q.cpu_stopped = 1'b1; //R15
					end
				end
				OFS_PWR_EN: next_q.rdata = {15'h0000, q.pwr_fn};
				default: next_q.rdata = 16'h0000;
			endcase
		end
		// interrupt pin through two flops, then restart
		next_q.interrupt_request_in_sync = {q.interrupt_request_in_sync[0], interrupt_request_in};
		if (q.interrupt_request_in_sync[1] && q.cpu_stopped) begin
			next_q.cpu_stopped = 1'b0; //R16
		end
		// output clocks by divider; system clock never gated
		next_q.div_cnt = tick ? 4'h0 : q.div_cnt + 4'h1;
		next_q.sys_clk = tick ? ~q.sys_clk : q.sys_clk; //R17
		next_q.cpu_clk = next_q.sys_clk & ~next_q.cpu_stopped; //R15
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q <= '0; //R5 R13
		end else begin
			q <= next_q;
		end
	end

	assign io_rdata = q.rdata;
	assign bank_row_strobe_n = ~q.ras;
	assign phys_addr = q.phys;
	assign route_ems = q.to_ems;
	assign route_system = q.to_sys;
	assign route_io_channel = q.to_io;
	assign processor_clock_out = q.cpu_clk;
	assign system_clock_out = q.sys_clk;
	assign register_banks_enabled = ~q.banks_off;

	sequence power_armed_s;
		q.pwr_fn && io_rd && io_addr == OFS_BANK_CTRL && !q.cpu_stopped;
	endsequence

	sequence clock_held_s;
		!processor_clock_out [*2];
	endsequence

	sequence power_on_s;
		io_wr && io_addr == OFS_PWR_EN && io_wdata[0];
	endsequence

	sequence bank_off_write_s;
		io_wr && io_addr == OFS_BANK_CTRL && !io_wdata[0] && q.pwr_fn;
	endsequence

	dma_none_a: assert property (@(posedge core_clk) disable iff (rst) //R2
		mem_cycle && dma_cycle && !q.dma_tag[dma_channel] && !refresh
		&& !q.dma_tag[3'(dma_channel) + 3'd4] |=> !route_ems && bank_row_strobe_n == 4'hf)
		else $error("dma cycle with no select was translated");

	dma_alt_a: assert property (@(posedge core_clk) disable iff (rst) //R3
		dma_cycle && blk_slot[6] && q.dma_tag[dma_channel]
		|-> entry == q.alt_map[blk_slot[5:0]])
		else $error("dma alternate select not honoured");

	dma_cur_a: assert property (@(posedge core_clk) disable iff (rst) //R3
		dma_cycle && blk_slot[6] && !q.dma_tag[dma_channel]
		|-> entry == q.cur_map[blk_slot[5:0]])
		else $error("dma current map not used");

	cpu_none_a: assert property (@(posedge core_clk) disable iff (rst) //R4
		mem_cycle && !dma_cycle && q.master_en == 2'b00 |=> !route_ems)
		else $error("cpu cycle translated with maps off");

	page_off_a: assert property (@(posedge core_clk) disable iff (rst) //R6
		mem_cycle && !entry[ENT_EN] |=> route_system == !$past(planar_disabled)
		&& route_io_channel == $past(planar_disabled))
		else $error("disabled page misrouted");

	strobe_idle_a: assert property (@(posedge core_clk) disable iff (rst) //R22
		!mapped && !refresh |=> bank_row_strobe_n == 4'hf)
		else $error("row strobe active without translation");

	strobe_bank_a: assert property (@(posedge core_clk) disable iff (rst) //R7
		mapped && !refresh |=> $countones(~bank_row_strobe_n) == 1
		&& !bank_row_strobe_n[$past(entry[9:8])])
		else $error("wrong bank row strobe");

	par_clear_a: assert property (@(posedge core_clk) disable iff (rst) //R12
		io_wr && io_addr == OFS_PARITY && !io_wdata[PAR_FLAG] && !parity_event
		|=> !q.par_stat[PAR_FLAG])
		else $error("parity flag not cleared by zero write");

	par_set_a: assert property (@(posedge core_clk) disable iff (rst) //R11
		parity_event && q.par_en[PAR_FLAG] |=> q.par_stat[PAR_FLAG])
		else $error("enabled parity error not recorded");

	par_bit6_a: assert property (@(posedge core_clk) disable iff (rst) //R9
		io_rd && io_addr == OFS_PARITY
		|=> io_rdata[6] == 1'b0 && io_rdata[PAR_FLAG] == $past(q.par_stat[PAR_FLAG]))
		else $error("parity status read wrong");

	par_mask_a: assert property (@(posedge core_clk) disable iff (rst) //R11
		parity_event && !q.par_en[PAR_FLAG] && !q.par_stat[PAR_FLAG]
		|=> !q.par_stat[PAR_FLAG])
		else $error("masked parity error recorded");

	par_hold_a: assert property (@(posedge core_clk) disable iff (rst) //R8
		q.par_stat[PAR_FLAG] && !(io_wr && io_addr == OFS_PARITY)
		|=> q.par_stat[PAR_FLAG])
		else $error("parity flag lost without a write");

	clk_stop_a: assert property (@(posedge core_clk) disable iff (rst) //R15
		power_armed_s ##1 !q.interrupt_request_in_sync[1] |-> clock_held_s)
		else $error("processor clock not stopped");

	clk_restart_a: assert property (@(posedge core_clk) disable iff (rst) //R16
		q.cpu_stopped && q.interrupt_request_in_sync[1] |=> !q.cpu_stopped)
		else $error("interrupt did not restart processor clock");

	sys_run_a: assert property (@(posedge core_clk) disable iff (rst) //R17
		q.cpu_stopped && tick |=> system_clock_out != $past(system_clock_out))
		else $error("system clock stalled during shutdown");

	bank_on_a: assert property (@(posedge core_clk) disable iff (rst) //R14
		io_wr && !io_rd && io_addr == OFS_BANK_CTRL && q.pwr_fn
		|=> register_banks_enabled == $past(io_wdata[0]))
		else $error("bank control write not applied");

	bank_lock_a: assert property (@(posedge core_clk) disable iff (rst) //R14
		io_wr && io_addr == OFS_BANK_CTRL && !q.pwr_fn
		|=> $stable(register_banks_enabled))
		else $error("bank control changed without power enable");

	bank_off_a: assert property (@(posedge core_clk) disable iff (rst) //R14
		power_on_s ##2 bank_off_write_s |=> !register_banks_enabled)
		else $error("bank disable sequence ignored");

	banks_map_a: assert property (@(posedge core_clk) disable iff (rst) //R14
		mem_cycle && q.banks_off |=> !route_ems)
		else $error("translation while banks disabled");

	tag_write_a: assert property (@(posedge core_clk) disable iff (rst) //R21
		io_wr && io_addr == OFS_DMA_TAG |=> q.dma_tag == $past(io_wdata[7:0]))
		else $error("dma tag write lost");

	master_write_a: assert property (@(posedge core_clk) disable iff (rst) //R18
		io_wr && io_addr == OFS_MASTER |=> q.master_en == $past(io_wdata[1:0]))
		else $error("master enable write lost");

	route_one_a: assert property (@(posedge core_clk) disable iff (rst) //R6
		mem_cycle |=> $countones({route_ems, route_system, route_io_channel}) == 1)
		else $error("memory cycle not routed to exactly one target");

	route_idle_a: assert property (@(posedge core_clk) disable iff (rst) //R6
		!mem_cycle |=> !route_ems && !route_system && !route_io_channel)
		else $error("route active without memory cycle");

	phys_a: assert property (@(posedge core_clk) disable iff (rst) //R19
		mapped |=> phys_addr == {$past(entry[9:8]), $past(entry[6:0])})
		else $error("physical address bits wrong");

	refresh_a: assert property (@(posedge core_clk) disable iff (rst) //R22
		refresh |=> bank_row_strobe_n == 4'h0)
		else $error("row strobes not all active in refresh");

	slot_none_a: assert property (@(posedge core_clk) disable iff (rst) //R20
		mem_cycle && !blk_slot[6] |=> !route_ems)
		else $error("unmappable block translated");
endmodule

// ---- testbench/emc_cpu_model.sv ----
// processor-side i/o master model for the map control
`timescale 1ns/10ps
module emc_cpu_model (
	input wire logic core_clk,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [15:0] io_wdata,
	input wire logic [15:0] io_rdata
);
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 16'h0000;
	end
	// one-cycle strobe; data inverted once released
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge core_clk);
		io_wr <= 1'b0;
		io_wdata <= ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge core_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge core_clk);
		io_rd <= 1'b0;
		@(posedge core_clk);
		#1 d = io_rdata;
	endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the expanded memory map control
`timescale 1ns/10ps
module testbench;
	import emc_pkg::*;
	logic core_clk, rst, io_wr, io_rd, mem_cycle, dma_cycle, planar_disabled, refresh;
	logic parity_event, parity_odd, parity_even, interrupt_request_in;
	logic route_ems, route_system, route_io_channel, processor_clock_out;
	logic system_clock_out, register_banks_enabled;
	logic [15:0] io_addr, io_wdata, io_rdata, v;
	logic [1:0] dma_channel;
	logic [5:0] mem_block;
	logic [3:0] bank_row_strobe_n, parity_bank;
	logic [8:0] phys_addr;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int pc, sc;
	emc_ctrl u_emc_ctrl (.core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_cycle(mem_cycle),
		.dma_cycle(dma_cycle), .dma_channel(dma_channel), .mem_block(mem_block),
		.planar_disabled(planar_disabled), .refresh(refresh),
		.bank_row_strobe_n(bank_row_strobe_n), .phys_addr(phys_addr), .route_ems(route_ems),
		.route_system(route_system), .route_io_channel(route_io_channel),
		.parity_event(parity_event), .parity_odd(parity_odd), .parity_even(parity_even),
		.parity_bank(parity_bank), .interrupt_request_in(interrupt_request_in),
		.processor_clock_out(processor_clock_out), .system_clock_out(system_clock_out),
		.register_banks_enabled(register_banks_enabled));
	emc_cpu_model u_emc_cpu_model (.core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
		u_emc_cpu_model.rd(a, v);
		samples_checked++;
		if (v !== e) begin
			miscompares++;
			$display("BAD port %h exp %h got %h", a, e, v);
		end
	endtask
	task automatic chk_out(input string n, input logic [8:0] e, input logic [8:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// strobes_n then ems, system, io routes
	task automatic mc(input logic d, input logic [1:0] ch, input logic [5:0] b,
		input logic [6:0] e);
		@(posedge core_clk);
		mem_cycle <= 1'b1;
		dma_cycle <= d;
		dma_channel <= ch;
		mem_block <= b;
		@(posedge core_clk);
		#1 chk_out("mem", {2'b00, e}, {2'b00, bank_row_strobe_n, route_ems, route_system,
			route_io_channel});
	endtask
	task automatic perr(input logic o, input logic [3:0] bk);
		@(posedge core_clk);
		parity_event <= 1'b1;
		parity_odd <= o;
		parity_bank <= bk;
		@(posedge core_clk);
		parity_event <= 1'b0;
	endtask
	initial begin
		rst = 1'b1;
		{mem_cycle, dma_cycle, planar_disabled, refresh, parity_event} = 5'h00;
		{parity_odd, parity_even, interrupt_request_in} = 3'h0;
		dma_channel = 2'h0;
		mem_block = 6'h00;
		parity_bank = 4'h0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		chk_rd(OFS_DMA_TAG, 16'h0000);
		chk_rd(OFS_PARITY, 16'h0000);
		chk_rd(OFS_MASTER, 16'h0000);
		chk_rd(16'h0013, 16'h0000);
		u_emc_cpu_model.wr(OFS_DMA_TAG, 16'h00a5);
		chk_rd(OFS_DMA_TAG, 16'h00a5);
		u_emc_cpu_model.wr(OFS_CUR_PTR, 16'h0010);
		u_emc_cpu_model.wr(OFS_CUR_DATA, 16'h0285);
		u_emc_cpu_model.wr(OFS_ALT_PTR, 16'h0010);
		u_emc_cpu_model.wr(OFS_ALT_DATA, 16'h0183);
		u_emc_cpu_model.wr(OFS_CUR_PTR, 16'h0011);
		u_emc_cpu_model.wr(OFS_CUR_DATA, 16'h0005);
		chk_rd(OFS_CUR_DATA, 16'h0005);
		chk_rd(OFS_ALT_DATA, 16'h0183);
		for (int m = 0; m < 4; m++) begin
			u_emc_cpu_model.wr(OFS_MASTER, 16'(m));
			mc(1'b0, 2'h0, 6'h10, m == 0 ? 7'h7a : (m == 2 ? 7'h6c : 7'h5c));
		end
		chk_out("phys", 9'h105, phys_addr);
		mc(1'b0, 2'h0, 6'h28, 7'h7a);
		mc(1'b0, 2'h0, 6'h11, 7'h7a);
		@(posedge core_clk);
		planar_disabled <= 1'b1;
		mc(1'b0, 2'h0, 6'h11, 7'h79);
		@(posedge core_clk);
		refresh <= 1'b1;
		mc(1'b0, 2'h0, 6'h11, 7'h01);
		@(posedge core_clk);
		refresh <= 1'b0;
		planar_disabled <= 1'b0;
		u_emc_cpu_model.wr(OFS_MASTER, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			for (int p = 0; p < 4; p++) begin
				u_emc_cpu_model.wr(OFS_DMA_TAG, 16'((p & 1) << c | (p >> 1) << (c + 4)));
				mc(1'b1, 2'(c), 6'h10, p[0] ? 7'h6c : (p[1] ? 7'h5c : 7'h7a));
			end
		end
		u_emc_cpu_model.wr(OFS_PARITY, 16'h00bf);
		perr(1'b1, 4'h4);
		chk_rd(OFS_PARITY, 16'h00a4);
		u_emc_cpu_model.wr(OFS_PARITY, 16'h009f);
		chk_rd(OFS_PARITY, 16'h0084);
		u_emc_cpu_model.wr(OFS_PARITY, 16'h0000);
		perr(1'b1, 4'h8);
		chk_rd(OFS_PARITY, 16'h0000);
		u_emc_cpu_model.wr(OFS_BANK_CTRL, 16'h0000);
		#1 chk_out("banks", 9'h001, {8'h00, register_banks_enabled});
		u_emc_cpu_model.wr(OFS_PWR_EN, 16'h0001);
		u_emc_cpu_model.wr(OFS_BANK_CTRL, 16'h0000);
		#1 chk_out("banks", 9'h000, {8'h00, register_banks_enabled});
		u_emc_cpu_model.wr(OFS_BANK_CTRL, 16'h0001);
		#1 chk_out("banks", 9'h001, {8'h00, register_banks_enabled});
		u_emc_cpu_model.rd(OFS_BANK_CTRL, v);
		pc = 0;
		sc = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge core_clk);
			#1 pc += int'(processor_clock_out);
			sc += int'(system_clock_out);
		end
		chk_out("banks", 9'h000, {8'h00, register_banks_enabled});
		chk_out("cpu_clk_hi", 9'h000, 9'(pc));
		chk_out("sys_clk_hi", 9'h014, 9'(sc));
		@(posedge core_clk);
		interrupt_request_in <= 1'b1;
		pc = 0;
		repeat (30) begin
			@(posedge core_clk);
			#1 pc += int'(processor_clock_out);
		end
		chk_out("cpu_clk_on", 9'h001, {8'h00, pc > 0});
		tally_and_finish();
	end
endmodule
